// file: design/acf_clock_fault_cfg.sv
`timescale 1ns/1ps
module acf_clock_fault_cfg #(
  // Absence timeouts in cycles, one per code; shorten for simulation
  parameter int unsigned TimeoutCycles [8] = '{
    acf_pkg::to_cycles(acf_pkg::TO_NS[0]), acf_pkg::to_cycles(acf_pkg::TO_NS[1]),
    acf_pkg::to_cycles(acf_pkg::TO_NS[2]), acf_pkg::to_cycles(acf_pkg::TO_NS[3]),
    acf_pkg::to_cycles(acf_pkg::TO_NS[4]), acf_pkg::to_cycles(acf_pkg::TO_NS[5]),
    acf_pkg::to_cycles(acf_pkg::TO_NS[6]), acf_pkg::to_cycles(acf_pkg::TO_NS[7])}
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic [1:0] clockSeen,
  output logic            battMonPowerDown,
  output logic      [1:0] audio_serial_input_rate,
  output logic      [1:0] fault_gain_ramp_rate,
  output logic            overtempRetryEnable,
  output logic      [1:0] clockFaultActive,
  output logic      [1:0] clockFaultLatched,
  output logic            playbackMute
);

  // Configuration registers
  logic [7:0] lowPower_q, lowPower_d;          // Battery monitor control
  logic [7:0] sampleRate_q, sampleRate_d;      // Serial input rate
  logic [7:0] faultRecov_q, faultRecov_d;      // Latch-or-recover choice
  logic [7:0] faultTiming_q, faultTiming_d;    // Ramp rate and timeouts
  logic [7:0] protection_q, protection_d;      // Over-temperature retry
  logic [7:0] rdata_q, rdata_d;                // Registered read data

  // Detector state, one entry per detector
  logic [acf_pkg::CNT_W-1:0] absentCnt_q [2];  // Cycles without clock
  logic [acf_pkg::CNT_W-1:0] absentCnt_d [2];
  logic [1:0]                latched_q, latched_d;
  logic [1:0]                faultNow;         // Timeout reached
  logic [1:0]                latchSel;         // Latch instead of recover
  logic [2:0]                toCode [2];       // Timeout code per detector
  logic                      recoverWrite;     // Host recovery strobe

  // Register write path
  always_comb begin
    lowPower_d    = lowPower_q;
    sampleRate_d  = sampleRate_q;
    faultRecov_d  = faultRecov_q;
    faultTiming_d = faultTiming_q;
    protection_d  = protection_q;
    if (regWrite) begin
      case (regAddr)
        acf_pkg::OFS_LOW_POWER_CONFIG:   lowPower_d    = regWdata;
        acf_pkg::OFS_SAMPLE_RATE_CONFIG: sampleRate_d  = regWdata;
        acf_pkg::OFS_CLOCK_FAULT_RECOV:  faultRecov_d  = regWdata;
        acf_pkg::OFS_CLOCK_FAULT_TIMING: faultTiming_d = regWdata;
        acf_pkg::OFS_PROTECTION_CONFIG:  protection_d  = regWdata;
        default: begin
          // Unmapped writes are dropped
          lowPower_d = lowPower_q;
        end
      endcase
    end
  end

  // Register read path, answered one cycle after the strobe
  always_comb begin
    rdata_d = rdata_q;
    if (regRead) begin
      case (regAddr)
        acf_pkg::OFS_LOW_POWER_CONFIG:   rdata_d = lowPower_q;
        acf_pkg::OFS_SAMPLE_RATE_CONFIG: rdata_d = sampleRate_q;
        acf_pkg::OFS_CLOCK_FAULT_RECOV:  rdata_d = faultRecov_q;
        acf_pkg::OFS_CLOCK_FAULT_TIMING: rdata_d = faultTiming_q;
        acf_pkg::OFS_PROTECTION_CONFIG:  rdata_d = protection_q;
        default:                         rdata_d = acf_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // Register storage; reserved bits are kept as written
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lowPower_q    <= acf_pkg::RST_LOW_POWER_CONFIG;
      sampleRate_q  <= acf_pkg::RST_SAMPLE_RATE_CONFIG;
      faultRecov_q  <= acf_pkg::RST_CLOCK_FAULT_RECOV;
      faultTiming_q <= acf_pkg::RST_CLOCK_FAULT_TIMING;
      protection_q  <= acf_pkg::RST_PROTECTION_CONFIG;
      rdata_q       <= acf_pkg::RDATA_UNMAPPED;
    end else begin
      lowPower_q    <= lowPower_d;
      sampleRate_q  <= sampleRate_d;
      faultRecov_q  <= faultRecov_d;
      faultTiming_q <= faultTiming_d;
      protection_q  <= protection_d;
      rdata_q       <= rdata_d;
    end
  end

  // Field decode feeding the detectors
  assign latchSel[0]  = faultRecov_q[acf_pkg::BIT_FAULT1_LATCH_SHUTDOWN];
  assign latchSel[1]  = faultRecov_q[acf_pkg::BIT_FAULT2_LATCH_SHUTDOWN];
  assign toCode[0]    = faultTiming_q[acf_pkg::TO1_LSB +: 3];
  assign toCode[1]    = faultTiming_q[acf_pkg::TO2_LSB +: 3];
  // Recovery is any host write to the recovery register
  assign recoverWrite = regWrite && (regAddr == acf_pkg::OFS_CLOCK_FAULT_RECOV);

  // Absence counters: saturate at the selected timeout
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      absentCnt_d[i] = absentCnt_q[i];
      faultNow[i]    = (absentCnt_q[i] >= acf_pkg::CNT_W'(TimeoutCycles[toCode[i]]));
      if (clockSeen[i]) begin
        absentCnt_d[i] = '0;
      end else if (!faultNow[i]) begin
        absentCnt_d[i] = absentCnt_q[i] + acf_pkg::CNT_W'(1);
      end
    end
    // Latch on fault when chosen; the set beats a same-cycle recovery
    latched_d = (faultNow & latchSel) | (latched_q & {2{~recoverWrite}});
  end

  // Detector state registers
  generate
    for (genvar g = 0; g < 2; g++) begin : gDet
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          absentCnt_q[g] <= '0;
          latched_q[g]   <= 1'b0;
        end else begin
          absentCnt_q[g] <= absentCnt_d[g];
          latched_q[g]   <= latched_d[g];
        end
      end
    end
  endgenerate

  // Outputs; a timed-out detector in recover mode clears itself once clock returns
  assign regRdata                = rdata_q;
  assign battMonPowerDown        = lowPower_q[acf_pkg::BIT_BATT_MON_POWER_DOWN];
  assign audio_serial_input_rate = sampleRate_q[acf_pkg::RATE_LSB +: 2];
  assign overtempRetryEnable     = ~protection_q[acf_pkg::BIT_OVERTEMP_RETRY_DIS];
  assign clockFaultActive        = faultNow;
  assign clockFaultLatched       = latched_q;
  assign playbackMute            = |faultNow || |latched_q;

  // Ramp rate; the reserved code falls back to RAMP_15US
  always_comb begin
    case (acf_pkg::acf_ramp_t'(faultTiming_q[acf_pkg::RAMP_LSB +: 2]))
      acf_pkg::RAMP_15US: fault_gain_ramp_rate = acf_pkg::RAMP_15US;
      acf_pkg::RAMP_30US: fault_gain_ramp_rate = acf_pkg::RAMP_30US;
      acf_pkg::RAMP_60US: fault_gain_ramp_rate = acf_pkg::RAMP_60US;
      default:            fault_gain_ramp_rate = acf_pkg::RAMP_15US;
    endcase
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  batt_bit_a: assert property (
    regWrite && regAddr == acf_pkg::OFS_LOW_POWER_CONFIG
    |=> battMonPowerDown == $past(regWdata[acf_pkg::BIT_BATT_MON_POWER_DOWN]))
    else $error("battery bit wrong");
  rate_sel_a: assert property (
    regWrite && regAddr == acf_pkg::OFS_SAMPLE_RATE_CONFIG
    |=> audio_serial_input_rate == $past(regWdata[acf_pkg::RATE_LSB +: 2]))
    else $error("rate wrong");
  rate_rst_a: assert property (
    $rose(arst_n) |-> sampleRate_q == acf_pkg::RST_SAMPLE_RATE_CONFIG)
    else $error("rate reset wrong");
  latch2_a: assert property (
    faultNow[1] && latchSel[1] |=> latched_q[1])
    else $error("fault2 not latched");
  latch1_a: assert property (
    faultNow[0] && !latchSel[0] && !latched_q[0] |=> !latched_q[0])
    else $error("fault1 latched in recover mode");
  latch1_set_a: assert property (
    faultNow[0] && latchSel[0] |=> latched_q[0])
    else $error("fault1 not latched");
  ramp_rsvd_a: assert property (
    faultTiming_q[acf_pkg::RAMP_LSB +: 2] == acf_pkg::RAMP_RSVD
    |-> fault_gain_ramp_rate == acf_pkg::RAMP_15US)
    else $error("reserved ramp code passed");
  ramp_map_a: assert property (
    faultTiming_q[acf_pkg::RAMP_LSB +: 2] != acf_pkg::RAMP_RSVD
    |-> fault_gain_ramp_rate == faultTiming_q[acf_pkg::RAMP_LSB +: 2])
    else $error("ramp map wrong");
  mute_to_a: assert property (
    !clockSeen[0] && absentCnt_q[0] ==
    acf_pkg::CNT_W'(TimeoutCycles[toCode[0]]) - acf_pkg::CNT_W'(1) |=> playbackMute)
    else $error("no mute at timeout");
  mute2_to_a: assert property (
    !clockSeen[1] && absentCnt_q[1] ==
    acf_pkg::CNT_W'(TimeoutCycles[toCode[1]]) - acf_pkg::CNT_W'(1) |=> playbackMute)
    else $error("no mute at detector 2 timeout");
  clear2_a: assert property (
    clockSeen[1] && !latched_q[1] && !latchSel[1] |=> !faultNow[1])
    else $error("fault2 not recovered");
  retry_a: assert property (
    overtempRetryEnable != protection_q[acf_pkg::BIT_OVERTEMP_RETRY_DIS])
    else $error("retry polarity wrong");
  prot_rst_a: assert property (
    $rose(arst_n) |-> protection_q == acf_pkg::RST_PROTECTION_CONFIG)
    else $error("protection reset wrong");
  hold_a: assert property (
    latched_q[0] && !recoverWrite |=> latched_q[0] && playbackMute)
    else $error("latched shutdown left early");

  fault1_c: cover property (faultNow[0] ##1 clockSeen[0]);
  latch2_c: cover property (latched_q[1] ##1 recoverWrite);
  rsvd_c:   cover property (faultTiming_q[acf_pkg::RAMP_LSB +: 2] == acf_pkg::RAMP_RSVD);

endmodule

// file: design/acf_pkg.sv
// How it works
// - Bit 7 set powers battery monitor down
// - Rate field codes 8, 16, 48, 96 kHz
// - Sample-rate register resets to 32h
// - Detector 2: bit 3 picks recover or latch
// - Detector 1: bit 2 picks recover or latch
// - Bits 7-6 choose fault gain ramp rate
// - Detector 1 timeout from bits 5-3, reset 2h
// - Detector 2 timeout from bits 2-0, reset 1h
// - Bit 2 clear allows over-temperature auto retry
// - Protection register resets to 3h
package acf_pkg;

  // Register offsets on the control port
  localparam logic [7:0] OFS_LOW_POWER_CONFIG   = 8'h35;
  localparam logic [7:0] OFS_SAMPLE_RATE_CONFIG = 8'h36;
  localparam logic [7:0] OFS_CLOCK_FAULT_RECOV  = 8'h4f;
  localparam logic [7:0] OFS_CLOCK_FAULT_TIMING = 8'h50;
  localparam logic [7:0] OFS_PROTECTION_CONFIG  = 8'h58;

  // Reset values
  localparam logic [7:0] RST_LOW_POWER_CONFIG   = 8'h00;
  localparam logic [7:0] RST_SAMPLE_RATE_CONFIG = 8'h32;
  localparam logic [7:0] RST_CLOCK_FAULT_RECOV  = 8'h00;
  localparam logic [7:0] RST_CLOCK_FAULT_TIMING = 8'h11;
  localparam logic [7:0] RST_PROTECTION_CONFIG  = 8'h03;
  localparam logic [7:0] RDATA_UNMAPPED         = 8'h00;

  // Field positions
  localparam int BIT_BATT_MON_POWER_DOWN   = 7;
  localparam int BIT_FAULT2_LATCH_SHUTDOWN = 3;
  localparam int BIT_FAULT1_LATCH_SHUTDOWN = 2;
  localparam int BIT_OVERTEMP_RETRY_DIS    = 2;
  localparam int RATE_LSB                  = 0;
  localparam int RAMP_LSB                  = 6;
  localparam int TO1_LSB                   = 3;
  localparam int TO2_LSB                   = 0;

  // Audio serial input rate codes
  typedef enum logic [1:0] {
    RATE_8K  = 2'b00,
    RATE_16K = 2'b01,
    RATE_48K = 2'b10,
    RATE_96K = 2'b11
  } acf_rate_t;

  // Gain ramp-down rate codes; 2'b10 is reserved
  typedef enum logic [1:0] {
    RAMP_15US  = 2'b00,
    RAMP_30US  = 2'b01,
    RAMP_RSVD  = 2'b10,
    RAMP_60US  = 2'b11
  } acf_ramp_t;

  // Clock period and absence timeouts, in ns
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TO_NS [8] = '{10600, 21300, 42600, 85300,
                                        340000, 680000, 1360000, 2730000};
  localparam int CNT_W = 20;

  // Each time rounds down to whole cycles
  function automatic int unsigned to_cycles(input int unsigned ns);
    to_cycles = ns / CLK_PERIOD_NS;
  endfunction

endpackage

// file: tb/acf_host_model.sv
`timescale 1ns/1ps
module acf_host_model (
  input  wire logic       clock,
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  // Idle port: strobes low
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end

  // One byte write; data is inverted once released so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask

  // One byte read; data is registered, so it is taken a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    d = regRdata;
  endtask
endmodule

// file: tb/tb_acf_clock_fault_cfg.sv
`timescale 1ns/1ps
module tb_acf_clock_fault_cfg;
  localparam int unsigned ToCyc [8] = '{3, 4, 5, 6, 7, 8, 9, 10};  // Short timeouts
  logic       clock;
  logic       arst_n;
  logic [7:0] regAddr;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic [1:0] clockSeen;
  logic       battDown;
  logic [1:0] rate;
  logic [1:0] ramp;
  logic       retryEn;
  logic [1:0] faultActive;
  logic [1:0] faultLatched;
  logic       mute;
  logic [7:0] rdVal;
  int         miscompares;
  int         checked;

  // 250 MHz clock
  always #2 clock = ~clock;

  acf_host_model i_host (.clock(clock), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));

  acf_clock_fault_cfg #(.TimeoutCycles(ToCyc)) i_dut (.clock(clock), .arst_n(arst_n),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .clockSeen(clockSeen), .battMonPowerDown(battDown),
    .audio_serial_input_rate(rate), .fault_gain_ramp_rate(ramp),
    .overtempRetryEnable(retryEn), .clockFaultActive(faultActive),
    .clockFaultLatched(faultLatched), .playbackMute(mute));

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Read back one register
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, rdVal);
    chk(rdVal, exp);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Starve detector i, measure the timeout, then recover by clock or by host write
  task automatic fault(input int i, input logic lat);
    int n;
    n = 0;
    i_host.wr(8'h4f, lat ? (8'h04 << i) : 8'h00);
    clockSeen[i] = 1'b0;
    while (faultActive[i] !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    if (n >= 50) begin
      miscompares++;
      report_and_stop();
    end else begin
      chk(8'(n), 8'(i ? ToCyc[0] : ToCyc[7]));
      chk(mute, 1'b1);
      if (lat) begin
        // A recovery write while the fault still stands must lose to the set
        i_host.wr(8'h4f, 8'h04 << i);
        chk(faultLatched[i], 1'b1);
      end
      clockSeen[i] = 1'b1;
      repeat (2) @(negedge clock);
      chk(faultActive[i], 1'b0);
      chk(faultLatched[i], lat);
      chk(mute, lat);
      if (lat) begin
        i_host.wr(8'h4f, 8'h00);
        @(negedge clock);
        chk(faultLatched[i], 1'b0);
        chk(mute, 1'b0);
      end
    end
  endtask

  // Main sequence
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    clockSeen = 2'b11;
    miscompares = 0;
    checked = 0;
    repeat (20) @(negedge clock);
    arst_n = 1'b1;
    // Reset values and an unmapped offset
    rdchk(8'h35, 8'h00);
    rdchk(8'h36, 8'h32);
    rdchk(8'h4f, 8'h00);
    rdchk(8'h50, 8'h11);
    rdchk(8'h58, 8'h03);
    rdchk(8'h37, 8'h00);
    // Unmapped write is dropped and disturbs no neighbour
    i_host.wr(8'h37, 8'hff);
    rdchk(8'h37, 8'h00);
    rdchk(8'h36, 8'h32);
    chk(rate, 8'h02);
    chk(retryEn, 1'b1);
    // Battery monitor power-down
    i_host.wr(8'h35, 8'h80);
    chk(battDown, 1'b1);
    rdchk(8'h35, 8'h80);
    i_host.wr(8'h35, 8'h00);
    chk(battDown, 1'b0);
    // Every rate code and every ramp code, reserved one included
    for (int k = 0; k < 4; k++) begin
      i_host.wr(8'h36, 8'h30 | 8'(k));
      chk(rate, 8'(k));
      i_host.wr(8'h50, 8'(k << 6) | 8'h11);
      chk(ramp, (k == 2) ? 8'h00 : 8'(k));
    end
    // Over-temperature retry disable
    i_host.wr(8'h58, 8'h07);
    chk(retryEn, 1'b0);
    rdchk(8'h58, 8'h07);
    i_host.wr(8'h58, 8'h03);
    chk(retryEn, 1'b1);
    // Longest code on detector 1, shortest on detector 2
    i_host.wr(8'h50, 8'h38);
    fault(0, 1'b0);
    fault(0, 1'b1);
    fault(1, 1'b0);
    fault(1, 1'b1);
    report_and_stop();
  end
endmodule
